// ==== core/ptmr_top.sv ====
// Function
// - Four separate 2 KB regions give an 8192-byte target space.
// - Each region is its own single-port RAM.
// - Every location is one 32-bit word reached by single-word requests only.
// - Only one-word memory (32/64-bit address) and I/O requests are served; memory writes get no completion.
// - A valid memory or I/O read returns a completion carrying exactly one read word.
// - An I/O write returns a completion without data with successful status.
// - A one-word write stores its payload at the addressed word of the chosen region.
// - The region is chosen from the BAR match vector on receive user bits 9..2.
// - I/O maps to region 0, 64-bit memory to region 2 (both off by default), 32-bit memory to region 1 via BAR 0.
// - Option ROM window accesses go to region 3, flagged by match vector 0100_0000b.
// - The block only receives requests and returns completions, never originating requests.
// - The stream data width is selectable as 32, 64 or 128 bits.
// - Offsets beyond 2 KB in a wider aperture wrap onto the same 2 KB memory.
// - A request longer than one word is fully taken in and dropped with no completion.
`timescale 1ns/1ps
`default_nettype none
module ptmr_top
  import ptmr_pkg::*;
#(
  parameter int DATA_W = 64,
  parameter logic [7:0] IO_BAR_MASK = IO_BAR_DEF,
  parameter logic [7:0] M32_BAR_MASK = M32_BAR_DEF,
  parameter logic [7:0] M64_BAR_MASK = M64_BAR_DEF,
  parameter logic [7:0] ROM_BAR_MASK = ROM_BAR_DEF
) (
  input wire logic sys_clk, // User clock
  input wire logic nrst, // Async reset, active low
  input wire logic [15:0] cfg_completer_id, // Own bus/device/function
  input wire logic [DATA_W-1:0] rx_tdata, // Request stream data
  input wire logic [DATA_W/8-1:0] rx_tkeep, // Request byte keep
  input wire logic rx_tlast, // Request end of packet
  input wire logic rx_tvalid, // Request beat valid
  input wire logic [21:0] rx_tuser, // Request sideband, BAR hits at 9..2
  output logic rx_tready, // Request beat accepted
  output logic [DATA_W-1:0] tx_tdata, // Completion stream data
  output logic [DATA_W/8-1:0] tx_tkeep, // Completion byte keep
  output logic tx_tlast, // Completion end of packet
  output logic tx_tvalid, // Completion beat valid
  input wire logic tx_tready // Completion beat taken
);
  localparam int DWPB = DATA_W / 32;

  typedef enum logic [2:0] {S_RX, S_EXEC, S_RDWAIT, S_TX} ptmr_state_e;

  // ---------------------------------------------------------------
  // State
  // ---------------------------------------------------------------
  ptmr_state_e state_q, state_d;
  logic [31:0] hdr_q [HDR_DW];
  logic [31:0] hdr_d [HDR_DW];
  logic [2:0] rx_cnt_q, rx_cnt_d;
  logic [7:0] bar_q, bar_d;
  logic [31:0] cpl_q [4];
  logic [31:0] cpl_d [4];
  logic [2:0] cpl_ndw_q, cpl_ndw_d;
  logic [2:0] tx_idx_q, tx_idx_d;
  logic rx_ready_q, rx_ready_d;
  logic [DATA_W-1:0] tx_data_q, tx_data_d;
  logic [DATA_W/8-1:0] tx_keep_q, tx_keep_d;
  logic tx_last_q, tx_last_d;
  logic tx_valid_q, tx_valid_d;

  // ---------------------------------------------------------------
  // Header decode
  // ---------------------------------------------------------------
  logic [1:0] fmt;
  logic [4:0] ptype;
  logic four_dw, has_data, is_io, is_mem, len_ok, hit;
  logic [1:0] region;
  logic [WIDX_W-1:0] widx;
  logic [31:0] wdata;
  logic [3:0] fbe;

  assign fmt = hdr_q[0][FMT_HI:FMT_LO];
  assign ptype = hdr_q[0][TYPE_HI:TYPE_LO];
  assign four_dw = fmt[0];
  assign has_data = fmt[1];
  assign is_io = (ptype == TYPE_IO) && !four_dw;
  assign is_mem = (ptype == TYPE_MEM);
  assign len_ok = (hdr_q[0][LEN_HI:LEN_LO] == LEN_ONE);
  assign fbe = hdr_q[1][FBE_HI:0];
  // only the low word index is kept, so larger apertures wrap
  assign widx = four_dw ? hdr_q[3][ADDR_LSB +: WIDX_W] : hdr_q[2][ADDR_LSB +: WIDX_W];
  assign wdata = four_dw ? hdr_q[4] : hdr_q[3];

  // region chosen by BAR hit vector, not by address
  always_comb
  begin
    hit = 1'b1;
    region = 2'(REG_M32);
    // I/O, 64-bit and 32-bit memory region mapping
    if (is_io && |(bar_q & IO_BAR_MASK))
      region = 2'(REG_IO);
    // option ROM window to region 3
    else if (is_mem && !four_dw && |(bar_q & ROM_BAR_MASK))
      region = 2'(REG_ROM);
    else if (is_mem && four_dw && |(bar_q & M64_BAR_MASK))
      region = 2'(REG_M64);
    else if (is_mem && !four_dw && |(bar_q & M32_BAR_MASK))
      region = 2'(REG_M32);
    else
      hit = 1'b0;
  end

  // ---------------------------------------------------------------
  // Region memories
  // ---------------------------------------------------------------
  logic [31:0] rd_data [REGIONS];
  logic ram_we, ram_re;

  assign ram_we = (state_q == S_EXEC) && hit && len_ok && has_data;
  assign ram_re = (state_q == S_EXEC) && hit && len_ok && !has_data;

  // four 2 KB regions, 8192 bytes total
  for (genvar g = 0; g < REGIONS; g++)
  begin : g_region
    logic [31:0] mem [REGION_WORDS];
    always_ff @(posedge sys_clk)
    begin
      // one-word write with first byte enables
      // each location is one 32-bit word
      if (ram_we && region == 2'(g))
        for (int b = 0; b < 4; b++)
          if (fbe[b])
            mem[widx][8*b +: 8] <= wdata[8*b +: 8];
      if (ram_re && region == 2'(g))
        rd_data[g] <= mem[widx];
    end
  end

  // ---------------------------------------------------------------
  // Control and stream datapath
  // ---------------------------------------------------------------
  always_comb
  begin
    logic [3:0] idx;
    logic [31:0] cw0;
    logic [31:0] cw2;
    idx = '0;
    // routing fields copied from the request
    cw0 = {1'b0, 2'b10, TYPE_CPL, 1'b0, hdr_q[0][TC_HI:TC_LO], 6'h00,
           hdr_q[0][ATTR_HI:ATTR_LO], 2'b00, LEN_ONE};
    cw2 = {hdr_q[1][31:RID_LO], hdr_q[1][RID_LO-1:TAG_LO], 1'b0, widx[4:0], 2'b00};
    state_d = state_q;
    hdr_d = hdr_q;
    rx_cnt_d = rx_cnt_q;
    bar_d = bar_q;
    cpl_d = cpl_q;
    cpl_ndw_d = cpl_ndw_q;
    tx_idx_d = tx_idx_q;
    tx_data_d = tx_data_q;
    tx_keep_d = tx_keep_q;
    tx_last_d = tx_last_q;
    tx_valid_d = tx_valid_q;
    case (state_q)
      S_RX:
      begin
        if (rx_tvalid)
        begin
          // header words gathered per beat for any width
          for (int i = 0; i < DWPB; i++)
          begin
            idx = 4'(rx_cnt_q) + 4'(i);
            if (idx < 4'(HDR_DW))
              hdr_d[idx[2:0]] = rx_tdata[32*i +: 32];
          end
          if (rx_cnt_q == 3'h0)
            bar_d = rx_tuser[BAR_LSB +: 8];
          idx = 4'(rx_cnt_q) + 4'(DWPB);
          rx_cnt_d = (idx > 4'(HDR_DW)) ? 3'(HDR_DW) : idx[2:0];
          // whole packet taken in before judging
          if (rx_tlast)
          begin
            rx_cnt_d = 3'h0;
            state_d = S_EXEC;
          end
        end
      end
      S_EXEC:
      begin
        state_d = S_RX;
        // only single-word reads and I/O writes complete; memory writes get no completion
        if (hit && len_ok)
        begin
          if (!has_data)
            state_d = S_RDWAIT;
          // I/O write gets a successful completion without data
          else if (is_io)
          begin
            // Format bit 30 marks a data payload, so it is cleared here
            cpl_d[0] = {cw0[31], 1'b0, cw0[29:0]};
            cpl_d[1] = {cfg_completer_id, CPL_OK, 1'b0, CPL_BYTES};
            cpl_d[2] = cw2;
            cpl_ndw_d = CPL_DW_NODATA;
            tx_idx_d = 3'h0;
            state_d = S_TX;
          end
        end
      end
      S_RDWAIT:
      begin
        cpl_d[0] = cw0;
        cpl_d[1] = {cfg_completer_id, CPL_OK, 1'b0, CPL_BYTES};
        cpl_d[2] = cw2;
        cpl_d[3] = rd_data[region];
        cpl_ndw_d = CPL_DW_DATA;
        tx_idx_d = 3'h0;
        state_d = S_TX;
      end
      S_TX:
      begin
        if (tx_valid_q && tx_tready && tx_last_q)
        begin
          tx_valid_d = 1'b0;
          tx_last_d = 1'b0;
          state_d = S_RX;
        end
        else if ((!tx_valid_q || tx_tready) && tx_idx_q < cpl_ndw_q)
        begin
          tx_data_d = '0;
          tx_keep_d = '0;
          for (int i = 0; i < DWPB; i++)
          begin
            idx = 4'(tx_idx_q) + 4'(i);
            if (idx < 4'(cpl_ndw_q))
            begin
              tx_data_d[32*i +: 32] = cpl_q[idx[1:0]];
              tx_keep_d[4*i +: 4] = 4'hf;
            end
          end
          idx = 4'(tx_idx_q) + 4'(DWPB);
          tx_idx_d = (idx > 4'(cpl_ndw_q)) ? cpl_ndw_q : idx[2:0];
          tx_last_d = (idx >= 4'(cpl_ndw_q));
          tx_valid_d = 1'b1;
        end
        else if (tx_valid_q && tx_tready)
          tx_valid_d = 1'b0;
      end
      default:
        state_d = S_RX;
    endcase
    // Ready held low outside collection so the core stalls while we work
    rx_ready_d = (state_d == S_RX);
  end

  always_ff @(posedge sys_clk or negedge nrst)
  begin
    if (!nrst)
    begin
      state_q <= S_RX;
      for (int i = 0; i < HDR_DW; i++)
        hdr_q[i] <= '0;
      for (int i = 0; i < 4; i++)
        cpl_q[i] <= '0;
      rx_cnt_q <= '0;
      bar_q <= '0;
      cpl_ndw_q <= '0;
      tx_idx_q <= '0;
      rx_ready_q <= 1'b0;
      tx_data_q <= '0;
      tx_keep_q <= '0;
      tx_last_q <= 1'b0;
      tx_valid_q <= 1'b0;
    end
    else
    begin
      state_q <= state_d;
      hdr_q <= hdr_d;
      cpl_q <= cpl_d;
      rx_cnt_q <= rx_cnt_d;
      bar_q <= bar_d;
      cpl_ndw_q <= cpl_ndw_d;
      tx_idx_q <= tx_idx_d;
      rx_ready_q <= rx_ready_d;
      tx_data_q <= tx_data_d;
      tx_keep_q <= tx_keep_d;
      tx_last_q <= tx_last_d;
      tx_valid_q <= tx_valid_d;
    end
  end

  // transmit side only ever carries completions
  assign rx_tready = rx_ready_q;
  assign tx_tdata = tx_data_q;
  assign tx_tkeep = tx_keep_q;
  assign tx_tlast = tx_last_q;
  assign tx_tvalid = tx_valid_q;
endmodule // ptmr_top
`default_nettype wire

// ==== core/ptmr_pkg.sv ====
package ptmr_pkg;
  // ---------------------------------------------------------------
  // Target space geometry
  // ---------------------------------------------------------------
  localparam int REGIONS = 4;
  localparam int REGION_BYTES = 2048;
  localparam int REGION_WORDS = REGION_BYTES / 4;
  localparam int WIDX_W = $clog2(REGION_WORDS);
  localparam int REG_IO = 0;
  localparam int REG_M32 = 1;
  localparam int REG_M64 = 2;
  localparam int REG_ROM = 3;

  // ---------------------------------------------------------------
  // Default BAR match masks per region
  // ---------------------------------------------------------------
  localparam logic [7:0] IO_BAR_DEF = 8'h00;
  localparam logic [7:0] M32_BAR_DEF = 8'h01;
  localparam logic [7:0] M64_BAR_DEF = 8'h00;
  localparam logic [7:0] ROM_BAR_DEF = 8'h40;

  // ---------------------------------------------------------------
  // Packet header layout
  // ---------------------------------------------------------------
  localparam int HDR_DW = 5;
  localparam int BAR_LSB = 2;
  localparam int FMT_HI = 30;
  localparam int FMT_LO = 29;
  localparam int TYPE_HI = 28;
  localparam int TYPE_LO = 24;
  localparam int TC_HI = 22;
  localparam int TC_LO = 20;
  localparam int ATTR_HI = 13;
  localparam int ATTR_LO = 12;
  localparam int LEN_HI = 9;
  localparam int LEN_LO = 0;
  localparam int RID_LO = 16;
  localparam int TAG_LO = 8;
  localparam int FBE_HI = 3;
  localparam int ADDR_LSB = 2;
  localparam logic [4:0] TYPE_MEM = 5'h00;
  localparam logic [4:0] TYPE_IO = 5'h02;
  localparam logic [4:0] TYPE_CPL = 5'h0a;
  localparam logic [9:0] LEN_ONE = 10'h001;
  localparam logic [2:0] CPL_OK = 3'h0;
  localparam logic [11:0] CPL_BYTES = 12'h004;
  localparam logic [2:0] CPL_DW_NODATA = 3'h3;
  localparam logic [2:0] CPL_DW_DATA = 3'h4;
endpackage : ptmr_pkg

// ==== sim/ptmr_sva.sv ====
`timescale 1ns/1ps
`default_nettype none
module ptmr_chk
  import ptmr_pkg::*;
#(
  parameter int DATA_W = 64,
  parameter logic [7:0] IO_BAR_MASK = IO_BAR_DEF,
  parameter logic [7:0] M64_BAR_MASK = M64_BAR_DEF
) (
  input wire logic sys_clk, // Clock
  input wire logic nrst, // Reset
  input wire logic [15:0] cfg_completer_id, // Own id
  input wire logic [DATA_W-1:0] rx_tdata, // Req data
  input wire logic rx_tlast, // Req end
  input wire logic rx_tvalid, // Req valid
  input wire logic [21:0] rx_tuser, // Bar hits
  input wire logic rx_tready, // Req taken
  input wire logic [DATA_W-1:0] tx_tdata, // Cpl data
  input wire logic tx_tlast, // Cpl end
  input wire logic tx_tvalid, // Cpl valid
  input wire logic tx_tready // Cpl taken
);
  // --------------------------------
  // Request capture
  // --------------------------------
  logic rx_sof_q;
  logic tx_sof_q;
  logic [63:0] h_q;
  logic [7:0] b_q;
  logic ok;
  logic drop;
  always_ff @(posedge sys_clk or negedge nrst)
  begin
    if (!nrst)
    begin
      rx_sof_q <= 1'b1;
      tx_sof_q <= 1'b1;
      {h_q, b_q} <= '0;
    end
    else
    begin
      if (rx_tvalid && rx_tready)
        rx_sof_q <= rx_tlast;
      if (rx_tvalid && rx_tready && rx_sof_q)
        {h_q, b_q} <= {rx_tdata[63:0], rx_tuser[9:2]};
      if (tx_tvalid && tx_tready)
        tx_sof_q <= tx_tlast;
    end
  end
  // The first beat carries header words 0 and 1, so the kind is judged from the capture
  assign ok = h_q[9:0] == LEN_ONE && (h_q[28:24] == TYPE_MEM ?
    |(b_q & (h_q[29] ? M64_BAR_MASK : (M32_BAR_DEF | ROM_BAR_DEF))) :
    h_q[28:24] == TYPE_IO && |(b_q & IO_BAR_MASK));
  assign drop = !ok || (h_q[30] && h_q[28:24] == TYPE_MEM);
  default clocking cb @(posedge sys_clk);
  endclocking
  default disable iff (!nrst);
  sequence rq_end;
    rx_tvalid && rx_tready && rx_tlast;
  endsequence
  sequence rd_end;
    rq_end ##0 (ok && !h_q[30]);
  endsequence
  sequence iow_end;
    rq_end ##0 (ok && h_q[30] && h_q[28:24] == TYPE_IO);
  endsequence
  sequence drop_end;
    rq_end ##0 drop;
  endsequence
  tx_hold_a:
    assert property (tx_tvalid && !tx_tready |=> tx_tvalid && $stable(tx_tdata))
    else $error("cpl beat moved while stalled");
  rd_cpl_a:
    assert property (rd_end |=> !tx_tvalid [*3] ##1 tx_tvalid)
    else $error("read cpl late or early");
  iow_cpl_a:
    assert property (iow_end |=> !tx_tvalid [*2] ##1 tx_tvalid)
    else $error("io write cpl late or early");
  drop_quiet_a:
    assert property (drop_end |=> !tx_tvalid [*6])
    else $error("cpl for dropped or posted req");
  drop_ready_a:
    assert property (drop_end |-> ##2 rx_tready)
    else $error("ready not back after drop");
  rx_stall_a:
    assert property (rq_end |=> !rx_tready)
    else $error("ready held after req end");
  busy_excl_a:
    assert property (tx_tvalid |-> !rx_tready)
    else $error("req taken while cpl pending");
  cpl_hdr_a:
    assert property (tx_tvalid && tx_sof_q |-> tx_tdata[28:24] == TYPE_CPL &&
      tx_tdata[22:20] == h_q[22:20] && tx_tdata[13:12] == h_q[13:12] &&
      tx_tdata[63:48] == cfg_completer_id)
    else $error("cpl header mismatch");
  cpl_ids_a:
    assert property (tx_tvalid && !tx_sof_q |-> tx_tdata[31:8] == h_q[63:40])
    else $error("cpl requester or tag mismatch");
endmodule // ptmr_chk
`default_nettype wire

// ==== sim/ptmr_core_model.sv ====
`timescale 1ns/1ps
`default_nettype none
module ptmr_core_model (
  input wire logic sys_clk, // Clock
  output logic [63:0] rx_tdata, // Req data
  output logic [7:0] rx_tkeep, // Req keep
  output logic rx_tlast, // Req end
  output logic rx_tvalid, // Req valid
  output logic [21:0] rx_tuser, // Bar hits
  input wire logic rx_tready, // Req taken
  input wire logic [63:0] tx_tdata, // Cpl data
  input wire logic [7:0] tx_tkeep, // Cpl keep
  input wire logic tx_tvalid, // Cpl valid
  output logic tx_tready // Cpl taken
);
  // --------------------------------
  // Endpoint side of the stream
  // --------------------------------
  logic slow = 1'b0;
  logic [31:0] cq [$];
  initial
  begin
    {rx_tdata, rx_tlast, rx_tvalid, rx_tuser} = '0;
    rx_tkeep = 8'hff;
  end
  // Slow mode stalls every other beat to exercise holding
  always @(negedge sys_clk)
    tx_tready <= slow ? ~tx_tready : 1'b1;
  always @(posedge sys_clk)
    if (tx_tvalid && tx_tready)
    begin
      cq.push_back(tx_tdata[31:0]);
      if (tx_tkeep[4])
        cq.push_back(tx_tdata[63:32]);
    end
  task automatic send(input logic [5:0][31:0] p, input int n, input logic [7:0] bar);
    for (int b = 0; b < (n + 1) / 2; b++)
    begin
      rx_tdata = {p[2 * b + 1], p[2 * b]};
      rx_tlast = (b == (n - 1) / 2);
      rx_tvalid = 1'b1;
      rx_tuser = {12'h0, bar, 2'h0};
      // Ready is registered, so its low-phase level is what the next edge takes
      while (rx_tready !== 1'b1)
        @(negedge sys_clk);
      @(negedge sys_clk);
    end
    rx_tvalid = 1'b0;
    rx_tlast = 1'b0;
    rx_tdata = ~rx_tdata;
    rx_tuser = ~rx_tuser;
  endtask
endmodule // ptmr_core_model
`default_nettype wire

// ==== sim/ptmr_tb_top.sv ====
`timescale 1ns/1ps
`default_nettype none
module ptmr_tb_top
  import ptmr_pkg::*;
;
  // --------------------------------
  // Bench
  // --------------------------------
  logic sys_clk = 1'b0;
  logic nrst = 1'b0;
  logic [15:0] cfg_completer_id = 16'h0;
  logic [63:0] rx_tdata, tx_tdata;
  logic [7:0] rx_tkeep, tx_tkeep;
  logic rx_tlast, rx_tvalid, rx_tready, tx_tlast, tx_tvalid, tx_tready;
  logic [21:0] rx_tuser;
  logic [15:0] lf_q = 16'h003d;
  logic [7:0] barv [4] = '{8'h04, 8'h01, 8'h10, 8'h40};
  logic [31:0] dv [4];
  logic [12:0] a;
  int failures = 0;
  int checks = 0;
  ptmr_top #(.IO_BAR_MASK(8'h04), .M64_BAR_MASK(8'h10)) DUT (.*);
  ptmr_core_model M (.*);
  initial
  begin
    forever #12.5 sys_clk = ~sys_clk;
  end
  function automatic logic [15:0] rnd();
    lf_q = {lf_q[14:0], lf_q[15] ^ lf_q[13] ^ lf_q[12] ^ lf_q[10]};
    return lf_q;
  endfunction
  function automatic logic [31:0] dw0(input logic [1:0] f, input logic [4:0] ty,
      input logic [4:0] ta, input logic [9:0] ln);
    return {1'b0, f, ty, 1'b0, ta[4:2], 6'h0, ta[1:0], 2'h0, ln};
  endfunction
  task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
    checks++;
    if (got !== exp)
    begin
      failures++;
      $display("[ERR] %0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic report_and_stop();
    if (failures == 0 && checks > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask
  task automatic req(input int r, input logic w, input logic [12:0] ad, input logic [31:0] d,
      input logic [9:0] ln, input logic [7:0] bar);
    logic [5:0][31:0] p;
    logic [15:0] rt;
    logic [4:0] ta;
    logic [31:0] m;
    int n;
    rt = rnd();
    ta = 5'(rnd());
    n = (r == 2) ? 4 : 3;
    m = w ? 32'hffff_fc00 : 32'hffff_ffff;
    p = '0;
    p[0] = dw0({w, r == 2}, (r == 0) ? TYPE_IO : TYPE_MEM, ta, ln);
    p[1] = {rt, rt[15:8], 8'h0f};
    p[n - 1] = {19'h0, ad[12:2], 2'h0};
    p[n] = d;
    M.send(p, n + 32'(w), bar);
    if (ln != LEN_ONE || bar != barv[r] || (w && r != 0))
    begin
      repeat (12) @(negedge sys_clk);
      cmp(32'(M.cq.size()), 32'h0);
    end
    else
    begin
      for (int k = 0; k < 300 && M.cq.size() < 4 - w; k++)
        @(negedge sys_clk);
      cmp(32'(M.cq.size()), 32'(4 - w));
      cmp(M.cq.pop_front() & m, dw0({!w, 1'b0}, TYPE_CPL, ta, LEN_ONE) & m);
      cmp(M.cq.pop_front(), {cfg_completer_id, 4'h0, CPL_BYTES});
      cmp(M.cq.pop_front(), {rt, rt[15:8], 1'b0, ad[6:2], 2'h0});
      if (!w)
        cmp(M.cq.pop_front(), d);
    end
  endtask
  initial
  begin
    repeat (4) @(posedge sys_clk);
    @(negedge sys_clk);
    nrst = 1'b1;
    cfg_completer_id = rnd();
    @(negedge sys_clk);
    for (int it = 0; it < 24; it++)
    begin
      M.slow = it[0];
      a = (it == 0) ? 13'h0 : (it == 1) ? 13'h1ffc : 13'(rnd());
      for (int r = 0; r < 4; r++)
        dv[r] = {rnd(), rnd()};
      for (int r = 0; r < 4; r++)
        req(r, 1'b1, a, dv[r], LEN_ONE, barv[r]);
      for (int r = 0; r < 4; r++)
        req(r, 1'b0, a ^ 13'h0800, dv[r], LEN_ONE, barv[r]);
    end
    req(1, 1'b0, a, dv[1], 10'h002, barv[1]);
    req(1, 1'b0, a, dv[1], LEN_ONE, 8'h02);
    report_and_stop();
  end
  initial
  begin
    #2000000;
    failures++;
    report_and_stop();
  end
endmodule // ptmr_tb_top
bind ptmr_top ptmr_chk #(.DATA_W(DATA_W), .IO_BAR_MASK(IO_BAR_MASK),
  .M64_BAR_MASK(M64_BAR_MASK)) chk (.*);
`default_nettype wire
